// File: pkg/alu_consts.vh
/*
 * constants for the datapath: opcodes of the arithmetic unit, status flag
 * positions, pointer pair indices, multiplier modes and latency.
 * assumes inclusion by bare name from the design files.
 */
`ifndef ALU_CONSTS_VH
`define ALU_CONSTS_VH

// ************************************************************
// status flag positions
// ************************************************************
`define FLG_C 0
`define FLG_Z 1
`define FLG_N 2
`define FLG_V 3
`define FLG_S 4
`define FLG_H 5
`define FLG_T 6
`define FLG_I 7
`define SREG_RST 8'h00

// ************************************************************
// arithmetic unit opcodes
// ************************************************************
`define OP_ADD  5'h00
`define OP_ADC  5'h01
`define OP_SUB  5'h02
`define OP_SBC  5'h03
`define OP_AND  5'h04
`define OP_OR   5'h05
`define OP_EOR  5'h06
`define OP_MOV  5'h07
`define OP_CP   5'h08
`define OP_CPC  5'h09
`define OP_COM  5'h0A
`define OP_NEG  5'h0B
`define OP_INC  5'h0C
`define OP_DEC  5'h0D
`define OP_LSR  5'h0E
`define OP_ROR  5'h0F
`define OP_ASR  5'h10
`define OP_SWAP 5'h11
`define OP_ADIW 5'h12
`define OP_SBIW 5'h13
`define OP_BSET 5'h14
`define OP_BCLR 5'h15
`define OP_BST  5'h16
`define OP_BLD  5'h17
`define OP_SBR  5'h18
`define OP_CBR  5'h19

// ************************************************************
// multiplier modes
// ************************************************************
`define MUL_UU  3'h0
`define MUL_SS  3'h1
`define MUL_SU  3'h2
`define MUL_FUU 3'h3
`define MUL_FSS 3'h4
`define MUL_FSU 3'h5
`define MUL_LAT 2

// ************************************************************
// register file and pointer pairs
// ************************************************************
`define RF_DEPTH 32
`define RF_RST   8'h00
`define PTR_X_LO 5'h1A
`define PTR_Y_LO 5'h1C
`define PTR_Z_LO 5'h1E
`define MUL_DST  5'h00

`endif

// File: tb/cpu_alu_datapath_assertions.sv
/*
 * timing and flag checks on the datapath ports.
 * assumes binding to cpu_alu_datapath; one clock, async active-low reset.
 */
`timescale 1ns/1ps
`include "alu_consts.vh"
module alu_dp_checker #(
   parameter DW = 8,
   parameter AW = 5
) (
   input wire          mclk,
   input wire          rst_n,
   input wire          op_valid,
   input wire [4:0]    op_code,
   input wire [AW-1:0] rd_sel,
   input wire [AW-1:0] rr_sel,
   input wire          use_imm,
   input wire [DW-1:0] imm,
   input wire [2:0]    bit_sel,
   input wire          mul_start,
   input wire [7:0]    sreg_r,
   input wire [15:0]   ptr_x_r,
   input wire [15:0]   ptr_z_r,
   input wire [DW-1:0] result_r,
   input wire          mul_busy_r
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   wire alu_ok = op_valid && !mul_busy_r && !mul_start;
   sequence s_busy_tail; mul_busy_r ##1 !mul_busy_r; endsequence
   sequence s_adiw_x; alu_ok && op_code == `OP_ADIW && rd_sel == `PTR_X_LO ##1 !op_valid; endsequence
   sequence s_sbiw_z; alu_ok && op_code == `OP_SBIW && rd_sel == `PTR_Z_LO ##1 !op_valid; endsequence
   property p_busy_rise; mul_start && !mul_busy_r |=> mul_busy_r; endproperty
   property p_busy_len; $rose(mul_busy_r) |=> s_busy_tail; endproperty
   property p_busy_idle; !mul_start && !mul_busy_r |=> !mul_busy_r; endproperty
   property p_adiw_x; s_adiw_x |=> ptr_x_r == $past(ptr_x_r) + $past(imm[5:0], 2); endproperty
   property p_sbiw_z; s_sbiw_z |=> ptr_z_r == $past(ptr_z_r) - $past(imm[5:0], 2); endproperty
   property p_eor_z;
      alu_ok && op_code == `OP_EOR && rd_sel == rr_sel && !use_imm |=> sreg_r[1] && result_r == 0;
   endproperty
   property p_bset; alu_ok && op_code == `OP_BSET |=> sreg_r[$past(bit_sel)]; endproperty
   property p_bclr; alu_ok && op_code == `OP_BCLR |=> !sreg_r[$past(bit_sel)]; endproperty
   property p_mov_flags; alu_ok && op_code == `OP_MOV |=> $stable(sreg_r); endproperty
   property p_idle_hold;
      !op_valid && !mul_start && !mul_busy_r |=> $stable(result_r) && $stable(sreg_r);
   endproperty
   a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise");
   a_busy_len: assert property (p_busy_len) else $error("busy span wrong");
   a_busy_idle: assert property (p_busy_idle) else $error("busy without start");
   a_adiw_x: assert property (p_adiw_x) else $error("word add wrong");
   a_sbiw_z: assert property (p_sbiw_z) else $error("word subtract wrong");
   a_eor_z: assert property (p_eor_z) else $error("zero flag wrong");
   a_bset: assert property (p_bset) else $error("flag not set");
   a_bclr: assert property (p_bclr) else $error("flag not cleared");
   a_mov_flags: assert property (p_mov_flags) else $error("move changed flags");
   a_idle_hold: assert property (p_idle_hold) else $error("idle output changed");
endmodule
bind cpu_alu_datapath alu_dp_checker #(.DW(DW), .AW(AW)) u_alu_dp_checker (
   .mclk(mclk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code), .rd_sel(rd_sel),
   .rr_sel(rr_sel), .use_imm(use_imm), .imm(imm), .bit_sel(bit_sel), .mul_start(mul_start),
   .sreg_r(sreg_r), .ptr_x_r(ptr_x_r), .ptr_z_r(ptr_z_r), .result_r(result_r),
   .mul_busy_r(mul_busy_r));

// File: tb/cpu_alu_datapath_tb.sv
/*
 * self-checking bench for the datapath with a decoder stand-in.
 * assumes alu_consts.vh on the include path; results read via result_r.
 */
`timescale 1ns/1ps
`include "alu_consts.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module cpu_alu_datapath_tb;
   reg         mclk;
   reg         rst_n;
   int         fails;
   int         n_checks;
   wire        op_valid, use_imm, mul_start, mul_busy_r;
   wire [4:0]  op_code, rd_sel, rr_sel;
   wire [7:0]  imm, sreg_r, result_r;
   wire [2:0]  bit_sel, mul_mode;
   wire [15:0] ptr_x_r, ptr_y_r, ptr_z_r;
   reg  [15:0] prod [6] = '{16'h81FA, 16'h00FA, 16'hFEFA, 16'h03F4, 16'h01F4, 16'hFDF4};
   reg  [5:0]  cy = 6'h2D;
   cpu_alu_datapath u_cpu_alu_datapath (.mclk(mclk), .rst_n(rst_n), .op_valid(op_valid),
      .op_code(op_code), .rd_sel(rd_sel), .rr_sel(rr_sel), .use_imm(use_imm), .imm(imm),
      .bit_sel(bit_sel), .mul_start(mul_start), .mul_mode(mul_mode), .sreg_r(sreg_r),
      .ptr_x_r(ptr_x_r), .ptr_y_r(ptr_y_r), .ptr_z_r(ptr_z_r), .result_r(result_r),
      .mul_busy_r(mul_busy_r));
   op_issuer u_op_issuer (.mclk(mclk), .op_valid(op_valid), .op_code(op_code),
      .rd_sel(rd_sel), .rr_sel(rr_sel), .use_imm(use_imm), .imm(imm), .bit_sel(bit_sel),
      .mul_start(mul_start), .mul_mode(mul_mode));
   // ******************************
   // helpers
   // ******************************
   task automatic ld(input [4:0] r, input [7:0] v);
      begin
         u_op_issuer.issue(`OP_AND, r, r, 1'h1, 8'h00);
         u_op_issuer.issue(`OP_OR, r, r, 1'h1, v);
         `CHK(result_r, v)
      end
   endtask
   task automatic close_out;
      begin
         $display("checks %0d mismatches %0d", n_checks, fails);
         if (fails == 0 && n_checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   // ******************************
   // scenarios
   // ******************************
   task automatic t_arith;
      begin
         ld(5'h01, 8'h3C);
         ld(5'h02, 8'hC5);
         u_op_issuer.issue(`OP_ADD, 5'h01, 5'h02, 1'h0, 8'h00);
         `CHK(result_r, 8'h01)
         `CHK(sreg_r, 8'h21)
         ld(5'h03, 8'h00);
         u_op_issuer.issue(`OP_ADC, 5'h03, 5'h03, 1'h0, 8'h00);
         `CHK(result_r, 8'h01)
         u_op_issuer.issue(`OP_COM, 5'h02, 5'h02, 1'h0, 8'h00);
         `CHK(result_r, 8'h3A)
         `CHK(sreg_r[0], 1'h1)
         u_op_issuer.issue(`OP_EOR, 5'h01, 5'h01, 1'h0, 8'h00);
         `CHK({sreg_r[1], result_r}, 9'h100)
         u_op_issuer.issue(`OP_BSET, 5'h00, 5'h00, 1'h0, 8'h06);
         `CHK(sreg_r[6], 1'h1)
         u_op_issuer.issue(`OP_BCLR, 5'h00, 5'h00, 1'h0, 8'h06);
         `CHK(sreg_r[6], 1'h0)
      end
   endtask
   task automatic t_ptr;
      begin
         ld(5'h1A, 8'hFF);
         ld(5'h1B, 8'h12);
         ld(5'h1C, 8'hCD);
         ld(5'h1D, 8'hAB);
         ld(5'h1E, 8'h00);
         ld(5'h1F, 8'h56);
         @(negedge mclk);
         `CHK({ptr_x_r, ptr_y_r, ptr_z_r}, 48'h12FF_ABCD_5600)
         u_op_issuer.issue(`OP_ADIW, `PTR_X_LO, 5'h00, 1'h1, 8'h01);
         u_op_issuer.issue(`OP_SBIW, `PTR_Z_LO, 5'h00, 1'h1, 8'h01);
         @(negedge mclk);
         `CHK({ptr_x_r, ptr_z_r}, 32'h1300_55FF)
      end
   endtask
   task automatic t_mul;
      begin
         ld(5'h05, 8'hFE);
         ld(5'h06, 8'h83);
         for (int m = 0; m < 6; m++) begin
            u_op_issuer.mul(m[2:0], 5'h05, 5'h06);
            `CHK(mul_busy_r, 1'h1)
            @(negedge mclk);
            `CHK(mul_busy_r, 1'h1)
            @(negedge mclk);
            `CHK(result_r, prod[m][7:0])
            `CHK(sreg_r[1:0], {1'b0, cy[m]})
            `CHK(mul_busy_r, 1'h0)
            u_op_issuer.issue(`OP_MOV, 5'h04, 5'h01, 1'h0, 8'h00);
            `CHK(result_r, prod[m][15:8])
         end
      end
   endtask
   // result byte and flags H S V N Z C after each remaining opcode, flags only for BST, result only for BLD
   task automatic t_more;
      begin
         ld(5'h07, 8'h10);
         ld(5'h08, 8'h20);
         u_op_issuer.issue(`OP_SUB, 5'h07, 5'h08, 1'h0, 8'h00);
         `CHK({result_r, sreg_r[5:0]}, 14'h3C15)
         u_op_issuer.issue(`OP_SBC, 5'h07, 5'h08, 1'h0, 8'h00);
         `CHK({result_r, sreg_r[5:0]}, 14'h33F4)
         u_op_issuer.issue(`OP_CP, 5'h07, 5'h08, 1'h0, 8'h00);
         `CHK({result_r, sreg_r[5:0]}, 14'h33D4)
         u_op_issuer.issue(`OP_CPC, 5'h08, 5'h08, 1'h0, 8'h00);
         `CHK({result_r, sreg_r[5:0]}, 14'h33C0)
         u_op_issuer.issue(`OP_NEG, 5'h08, 5'h00, 1'h0, 8'h00);
         `CHK({result_r, sreg_r[5:0]}, 14'h3815)
         ld(5'h09, 8'h7F);
         u_op_issuer.issue(`OP_INC, 5'h09, 5'h00, 1'h0, 8'h00);
         `CHK({result_r, sreg_r[5:0]}, 14'h200D)
         u_op_issuer.issue(`OP_DEC, 5'h09, 5'h00, 1'h0, 8'h00);
         `CHK({result_r, sreg_r[5:0]}, 14'h1FD9)
         u_op_issuer.issue(`OP_LSR, 5'h09, 5'h00, 1'h0, 8'h00);
         `CHK({result_r, sreg_r[5:0]}, 14'h0FD9)
         u_op_issuer.issue(`OP_ROR, 5'h09, 5'h00, 1'h0, 8'h00);
         `CHK({result_r, sreg_r[5:0]}, 14'h27D5)
         u_op_issuer.issue(`OP_ASR, 5'h09, 5'h00, 1'h0, 8'h00);
         `CHK({result_r, sreg_r[5:0]}, 14'h33D5)
         u_op_issuer.issue(`OP_SWAP, 5'h09, 5'h00, 1'h0, 8'h00);
         `CHK({result_r, sreg_r[5:0]}, 14'h3F15)
         ld(5'h0A, 8'h00);
         u_op_issuer.issue(`OP_BST, 5'h09, 5'h00, 1'h0, 8'h02);
         `CHK(sreg_r, 8'h43)
         u_op_issuer.issue(`OP_BLD, 5'h0A, 5'h00, 1'h0, 8'h00);
         `CHK(result_r, 8'h01)
         u_op_issuer.issue(`OP_SBR, 5'h0A, 5'h00, 1'h1, 8'hF0);
         `CHK({result_r, sreg_r}, 16'hF155)
         u_op_issuer.issue(`OP_CBR, 5'h0A, 5'h00, 1'h1, 8'h0F);
         `CHK({result_r, sreg_r}, 16'hF055)
         u_op_issuer.issue(5'h1F, 5'h02, 5'h00, 1'h0, 8'h00);
         `CHK({result_r, sreg_r}, 16'hF055)
      end
   endtask
   // ******************************
   // clock, reset, sequence
   // ******************************
   initial begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      repeat (3000) @(posedge mclk);
      fails++;
      close_out();
   end
   initial begin
      fails = 0;
      n_checks = 0;
      rst_n = 1'h0;
      repeat (10) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'h1;
      `CHK({sreg_r, result_r, ptr_x_r, mul_busy_r}, 33'h0)
      t_arith();
      t_ptr();
      t_mul();
      t_more();
      close_out();
   end
endmodule

// File: tb/op_issuer.sv
/*
 * decoder stand-in: issues single operations and multiply starts.
 * assumes the bench calls its tasks; inputs change on the falling edge.
 */
`timescale 1ns/1ps
module op_issuer (
   input  wire       mclk,
   output reg        op_valid,
   output reg  [4:0] op_code,
   output reg  [4:0] rd_sel,
   output reg  [4:0] rr_sel,
   output reg        use_imm,
   output reg  [7:0] imm,
   output reg  [2:0] bit_sel,
   output reg        mul_start,
   output reg  [2:0] mul_mode
);
   initial begin
      {op_valid, op_code, rd_sel, rr_sel, use_imm, imm, bit_sel, mul_start, mul_mode} = '0;
   end
   // one operation, held across exactly one sampling edge
   task automatic issue(input [4:0] op, input [4:0] rd, input [4:0] rr, input ui,
                        input [7:0] im);
      begin
         @(negedge mclk);
         op_valid = 1'h1;
         op_code = op;
         rd_sel = rd;
         rr_sel = rr;
         use_imm = ui;
         imm = im;
         bit_sel = im[2:0];
         @(negedge mclk);
         op_valid = 1'h0;
      end
   endtask
   // one-cycle start pulse; the bench waits out the busy span
   task automatic mul(input [2:0] m, input [4:0] rd, input [4:0] rr);
      begin
         @(negedge mclk);
         mul_start = 1'h1;
         mul_mode = m;
         rd_sel = rd;
         rr_sel = rr;
         @(negedge mclk);
         mul_start = 1'h0;
      end
   endtask
endmodule

// File: verilog/cpu_alu_datapath.v
/*
 * datapath of an 8-bit core: 32x8 working registers, pointer pairs,
 * arithmetic unit with status register, and two-cycle multiplier.
 * assumes the decoder drives operation, register selects and immediate
 * synchronously, one operation per cycle, and waits out the multiplier.
 */
// Behaviour
// RQ1: operations take two registers or a register and an immediate.
// RQ2: single-register operations use only the destination register.
// RQ3: thirty-two working registers of eight bits, all usable by the unit.
// RQ4: any register is read combinationally, so operations finish in one cycle.
// RQ5: a single-cycle result is written back at the end of its cycle.
// RQ6: six top registers form three 16-bit pointers for program and data.
// RQ7: status register is updated after each arithmetic or logic operation.
// RQ8: arithmetic, logical and bit manipulation classes are all provided.
// RQ9: 8-bit and 16-bit arithmetic with carry chaining for wider words.
// RQ10: multiplier takes two bytes and gives a 16-bit product.
// RQ11: six modes: unsigned, signed, signed-unsigned, integer and fractional.
// RQ12: product is available two cycles after the multiply starts.
// RQ13: fractional products are shifted left by one bit.
// RQ14: flags derive customarily; unaffected flags keep their value.
`timescale 1ns/1ps
`include "alu_consts.vh"

module cpu_alu_datapath #(
   parameter DW = 8,
   parameter AW = 5
) (
   input  wire          mclk,
   input  wire          rst_n,
   input  wire          op_valid,
   input  wire [4:0]    op_code,
   input  wire [AW-1:0] rd_sel,
   input  wire [AW-1:0] rr_sel,
   input  wire          use_imm,
   input  wire [DW-1:0] imm,
   input  wire [2:0]    bit_sel,
   input  wire          mul_start,
   input  wire [2:0]    mul_mode,
   output reg  [7:0]    sreg_r,
   output reg  [15:0]   ptr_x_r,
   output reg  [15:0]   ptr_y_r,
   output reg  [15:0]   ptr_z_r,
   output reg  [DW-1:0] result_r,
   output reg           mul_busy_r
);

   reg  [DW-1:0] rf [0:`RF_DEPTH-1];
   reg  [DW-1:0] a;
   reg  [DW-1:0] b;
   reg  [DW-1:0] res;
   reg  [15:0]   wa;
   reg  [15:0]   wres;
   reg  [7:0]    sreg_nxt;
   reg           wr_en;
   reg           wr_word;
   reg           c_in;
   reg  [DW:0]   sum;
   wire [15:0]   prod;
   wire          prod_c;
   wire          mul_done;
   integer       i;

   // plain add or subtract with carry-in, returns carry in the top bit
   function [8:0] addsub;
      input [7:0] x;
      input [7:0] y;
      input       sub;
      input       ci;
      begin
         if (sub)
            addsub = {1'b0, x} - {1'b0, y} - {8'h00, ci};
         else
            addsub = {1'b0, x} + {1'b0, y} + {8'h00, ci};
      end
   endfunction

   hw_mult #(
      .W (DW)
   ) u_mult (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .start   (mul_start),
      .mode    (mul_mode),
      .a       (rf[rd_sel]),
      .b       (rf[rr_sel]),
      .prod_r  (prod),
      .carry_r (prod_c),
      .done_r  (mul_done)
   );

   // ************************************************************
   // operand fetch and result computation
   // ************************************************************
   always @* begin
      a        = rf[rd_sel]; // RQ4 RQ3
      b        = use_imm ? imm : rf[rr_sel]; // RQ1
      wa       = {rf[rd_sel + 5'h01], rf[rd_sel]};
      c_in     = sreg_r[`FLG_C];
      sreg_nxt = sreg_r; // RQ14
      res      = a;
      wres     = wa;
      wr_en    = 1'b0;
      wr_word  = 1'b0;
      sum      = 9'h000;
      if (op_valid) begin
         case (op_code) // RQ8
            `OP_ADD, `OP_ADC: begin
               sum = addsub(a, b, 1'b0, (op_code == `OP_ADC) & c_in); // RQ9
               res = sum[7:0];
               wr_en = 1'b1;
               sreg_nxt[`FLG_C] = sum[8];
               sreg_nxt[`FLG_H] = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
               sreg_nxt[`FLG_V] = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
            end
            `OP_SUB, `OP_SBC, `OP_CP, `OP_CPC, `OP_NEG: begin
               if (op_code == `OP_NEG)
                  sum = addsub(8'h00, a, 1'b1, 1'b0);
               else
                  sum = addsub(a, b, 1'b1,
                               (op_code == `OP_SBC || op_code == `OP_CPC) & c_in);
               res = sum[7:0];
               wr_en = (op_code != `OP_CP) && (op_code != `OP_CPC);
               sreg_nxt[`FLG_C] = sum[8];
               if (op_code == `OP_NEG) begin
                  sreg_nxt[`FLG_H] = res[3] | a[3];
                  sreg_nxt[`FLG_V] = (res == 8'h80);
               end else begin
                  sreg_nxt[`FLG_H] = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
                  sreg_nxt[`FLG_V] = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
               end
            end
            `OP_AND, `OP_OR, `OP_EOR, `OP_SBR, `OP_CBR: begin
               if (op_code == `OP_AND)
                  res = a & b;
               else if (op_code == `OP_CBR)
                  res = a & ~b;
               else if (op_code == `OP_EOR)
                  res = a ^ b;
               else
                  res = a | b;
               wr_en = 1'b1;
               sreg_nxt[`FLG_V] = 1'b0;
            end
            `OP_COM: begin // RQ2
               res = ~a;
               wr_en = 1'b1;
               sreg_nxt[`FLG_C] = 1'b1;
               sreg_nxt[`FLG_V] = 1'b0;
            end
            `OP_INC, `OP_DEC: begin
               res = (op_code == `OP_INC) ? a + 8'h01 : a - 8'h01;
               wr_en = 1'b1;
               sreg_nxt[`FLG_V] = (op_code == `OP_INC) ? (res == 8'h80) : (res == 8'h7F);
            end
            `OP_LSR, `OP_ROR, `OP_ASR: begin
               if (op_code == `OP_LSR)
                  res = {1'b0, a[7:1]};
               else if (op_code == `OP_ROR)
                  res = {c_in, a[7:1]};
               else
                  res = {a[7], a[7:1]};
               wr_en = 1'b1;
               sreg_nxt[`FLG_C] = a[0];
               sreg_nxt[`FLG_V] = res[7] ^ a[0];
            end
            `OP_SWAP: begin
               res = {a[3:0], a[7:4]};
               wr_en = 1'b1;
            end
            `OP_MOV: begin
               res = b;
               wr_en = 1'b1;
            end
            `OP_ADIW, `OP_SBIW: begin
               wres = (op_code == `OP_ADIW) ? wa + {10'h000, imm[5:0]}
                                             : wa - {10'h000, imm[5:0]}; // RQ9
               wr_en = 1'b1;
               wr_word = 1'b1;
               if (op_code == `OP_ADIW) begin
                  sreg_nxt[`FLG_C] = ~wres[15] & wa[15];
                  sreg_nxt[`FLG_V] = wres[15] & ~wa[15];
               end else begin
                  sreg_nxt[`FLG_C] = wres[15] & ~wa[15];
                  sreg_nxt[`FLG_V] = ~wres[15] & wa[15];
               end
               sreg_nxt[`FLG_N] = wres[15];
               sreg_nxt[`FLG_Z] = (wres == 16'h0000);
               sreg_nxt[`FLG_S] = wres[15] ^ sreg_nxt[`FLG_V];
            end
            `OP_BSET: sreg_nxt[bit_sel] = 1'b1;
            `OP_BCLR: sreg_nxt[bit_sel] = 1'b0;
            `OP_BST:  sreg_nxt[`FLG_T] = a[bit_sel];
            `OP_BLD: begin
               res = a;
               res[bit_sel] = sreg_r[`FLG_T];
               wr_en = 1'b1;
            end
            default: res = a;
         endcase
         // common result flags for byte operations
         // unknown opcodes above the last defined one leave every flag alone
         if (op_code <= `OP_CBR && !wr_word && // RQ14
             op_code != `OP_MOV && op_code != `OP_SWAP &&
             op_code != `OP_BSET && op_code != `OP_BCLR && op_code != `OP_BST &&
             op_code != `OP_BLD) begin
            sreg_nxt[`FLG_N] = res[7];
            if (op_code == `OP_SBC || op_code == `OP_CPC)
               sreg_nxt[`FLG_Z] = (res == 8'h00) & sreg_r[`FLG_Z]; // RQ9
            else
               sreg_nxt[`FLG_Z] = (res == 8'h00);
            sreg_nxt[`FLG_S] = res[7] ^ sreg_nxt[`FLG_V];
         end
      end
      if (mul_done) begin
         sreg_nxt[`FLG_C] = prod_c; // RQ7
         sreg_nxt[`FLG_Z] = (prod == 16'h0000);
      end
   end

   // ************************************************************
   // register file, status and pointer write-back
   // ************************************************************
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < `RF_DEPTH; i = i + 1)
            rf[i] <= `RF_RST;
         sreg_r     <= `SREG_RST;
         result_r   <= 8'h00;
         mul_busy_r <= 1'b0;
      end else begin
         sreg_r <= sreg_nxt; // RQ7
         if (mul_start)
            mul_busy_r <= 1'b1;
         else if (mul_done)
            mul_busy_r <= 1'b0;
         if (mul_done) begin
            rf[`MUL_DST]         <= prod[7:0]; // RQ12
            rf[`MUL_DST + 5'h01] <= prod[15:8];
            result_r             <= prod[7:0];
         end else if (wr_en && wr_word) begin
            rf[rd_sel]         <= wres[7:0];
            rf[rd_sel + 5'h01] <= wres[15:8];
            result_r           <= wres[7:0];
         end else if (wr_en) begin
            rf[rd_sel] <= res; // RQ5
            result_r   <= res;
         end
      end
   end

   // pointer outputs mirror the register pairs one cycle later
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_x_r <= 16'h0000;
         ptr_y_r <= 16'h0000;
         ptr_z_r <= 16'h0000;
      end else begin
         ptr_x_r <= {rf[`PTR_X_LO + 5'h01], rf[`PTR_X_LO]}; // RQ6
         ptr_y_r <= {rf[`PTR_Y_LO + 5'h01], rf[`PTR_Y_LO]}; // RQ6
         ptr_z_r <= {rf[`PTR_Z_LO + 5'h01], rf[`PTR_Z_LO]}; // RQ6
      end
   end

endmodule

// File: verilog/hw_mult.v
/*
 * two-cycle 8x8 multiplier with signed, unsigned and fractional modes.
 * assumes start is a one-cycle pulse with operands valid in that cycle.
 */
`timescale 1ns/1ps
`include "alu_consts.vh"

module hw_mult #(
   parameter W = 8
) (
   input  wire           mclk,
   input  wire           rst_n,
   input  wire           start,
   input  wire [2:0]     mode,
   input  wire [W-1:0]   a,
   input  wire [W-1:0]   b,
   output reg  [2*W-1:0] prod_r,
   output reg            carry_r,
   output reg            done_r
);

   reg [W:0]     a_x;
   reg [W:0]     b_x;
   reg [2*W+1:0] full;
   reg           frac;
   reg [2*W-1:0] p1_r;
   reg           frac_r;
   reg           busy_r;

   always @* begin
      a_x  = {1'b0, a};
      b_x  = {1'b0, b};
      frac = (mode == `MUL_FUU) || (mode == `MUL_FSS) || (mode == `MUL_FSU);
      if (mode == `MUL_SS || mode == `MUL_FSS || mode == `MUL_SU || mode == `MUL_FSU)
         a_x = {a[W-1], a};
      if (mode == `MUL_SS || mode == `MUL_FSS)
         b_x = {b[W-1], b};
      full = $signed(a_x) * $signed(b_x); // RQ10 RQ11
   end

   // ************************************************************
   // stage one takes the product, stage two scales and presents it
   // ************************************************************
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         p1_r    <= 16'h0000;
         frac_r  <= 1'b0;
         busy_r  <= 1'b0;
         prod_r  <= 16'h0000;
         carry_r <= 1'b0;
         done_r  <= 1'b0;
      end else begin
         busy_r <= start; // RQ12
         done_r <= busy_r; // RQ12
         if (start) begin
            p1_r   <= full[2*W-1:0];
            frac_r <= frac;
         end
         if (busy_r) begin
            carry_r <= p1_r[2*W-1];
            if (frac_r)
               prod_r <= {p1_r[2*W-2:0], 1'b0}; // RQ13
            else
               prod_r <= p1_r;
         end
      end
   end

endmodule
